// ===== inc/sflash_pkg.sv
// constants, opcodes and types for the serial flash command engine
package sflash_pkg;
  // opcodes
  localparam logic [7:0] OP_DUAL_PROG = 8'hA2;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG  = 8'h42;
  localparam logic [7:0] OP_SEC_READ  = 8'h48;
  localparam logic [7:0] OP_SLEEP     = 8'hB9;
  localparam logic [7:0] OP_RELEASE   = 8'hAB;
  // header bit counts on the single line
  localparam logic [5:0] HDR_OP   = 6'h08;
  localparam logic [5:0] HDR_ADDR = 6'h20;
  localparam logic [5:0] HDR_READ = 6'h28;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // address fields
  localparam int ADR_TOP_MSB = 23;
  localparam int ADR_TOP_LSB = 16;
  localparam int ADR_AREA_MSB = 15;
  localparam int ADR_AREA_LSB = 12;
  localparam int ADR_GAP_MSB = 11;
  localparam int ADR_GAP_LSB = 10;
  localparam int ADR_OFF_MSB = 9;
  localparam int ADR_PAGE_MSB = 7;
  localparam logic [3:0] AREA_LAST = 4'h3;
  // buffer geometry
  localparam logic [9:0]  PAGE_MASK = 10'h0FF;
  localparam logic [9:0]  SEC_MASK  = 10'h3FF;
  localparam logic [10:0] PAGE_LEN  = 11'h100;
  localparam logic [10:0] SEC_LEN   = 11'h400;
  localparam int SEC_BYTES = 3072;
  localparam int BUF_BYTES = 1024;
  localparam logic [7:0] ERASED = 8'hFF;
  // timing: least times, rounded up to whole 50 ns cycles
  localparam int CLK_MHZ = 20;
  localparam int SECTOR_ERASE_TIME_US = 300000;
  localparam int PROGRAM_CYCLE_TIME_US = 3000;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int SLEEP_RELEASE_DELAY_NS = 8000;
  localparam int SE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int PP_CYC = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
  localparam int DP_CYC = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int RES_CYC = (SLEEP_RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;
  // summary of one chip-select frame, held while select is high
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [5:0]  hdr;
    logic        dok;
    logic [10:0] nb;
  } frame_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ENTER = 3'h1,
    ST_SLEEP = 3'h3,
    ST_WAKE  = 3'h2,
    ST_BUSY  = 3'h4
  } state_t;
  typedef enum logic [1:0] {
    K_PAGE  = 2'h0,
    K_SPROG = 2'h1,
    K_ERASE = 2'h2
  } kind_t;
endpackage

// ===== hdl/sflash_exec.sv
// serial flash command engine: dual/quad program, secure areas, deep sleep
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - dual program takes 1 to 256 bytes
// - dual data: two bits per clock, io0/io1
// - quad: 32h, address on io0, 4-bit data
// - three 1024-byte secure areas
// - secure area chosen by address bits 15-12
// - erase self-timed, progress flag high meanwhile
// - lock bit set blocks erase and program
// - secure program 42h, 1 to 1024 bytes
// - secure program self-timed, progress flag high
// - secure read 48h, dummy byte, falling-edge out
// - read offset wraps 3FFh to 000h
// - sleep entry waits entry delay
// - asleep: ignore all but release
// - power-up in standby, never asleep
// - page data wraps, last 256 kept
// - program end clears progress and latch
// - release reaches standby after release delay
`timescale 1ns/10ps
`default_nettype none
module sflash_exec #(
  parameter int unsigned PP_CYC = sflash_pkg::PP_CYC,
  parameter int unsigned SE_CYC = sflash_pkg::SE_CYC
) (
  // system clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // serial link pins
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  // status bits held elsewhere
  input  wire logic        write_enable_latch_i,
  input  wire logic        quad_enable_bit_i,
  input  wire logic [2:0]  secure_area_lock_bits_i,
  input  wire logic [4:0]  block_protect_bits_i,
  // status out
  output logic             write_in_progress_o,
  output logic             wel_clear_o,
  output logic             deep_sleep_o,
  // main array program port
  output logic             arr_we_o,
  output logic      [23:0] arr_addr_o,
  output logic      [7:0]  arr_data_o
);
  //////////////////////////////////////////////////////////////////////////////
  // link domain (sclk_i)
  sflash_pkg::frame_t frame_q;
  logic [5:0]  hdr_q;
  logic [5:0]  hdr_d;
  logic [3:0]  dcnt_q;
  logic [3:0]  dnext;
  logic [7:0]  dsr_q;
  logic [7:0]  dbyte;
  logic [2:0]  lanes;
  logic [12:0] rcnt_q;
  logic [9:0]  widx;
  logic        in_data;
  logic        blk_s1_q;
  logic        blk_s2_q;
  logic [7:0]  wbuf [sflash_pkg::BUF_BYTES];
  logic [7:0]  sec_mem [sflash_pkg::SEC_BYTES];

  // secure address check: top byte zero, gap zero, area 1..3
  function automatic logic sec_ok(input logic [23:0] a);
    logic [3:0] ar;
    ar = a[sflash_pkg::ADR_AREA_MSB:sflash_pkg::ADR_AREA_LSB];
    sec_ok = (a[sflash_pkg::ADR_TOP_MSB:sflash_pkg::ADR_TOP_LSB] == 8'h00) &&
             (a[sflash_pkg::ADR_GAP_MSB:sflash_pkg::ADR_GAP_LSB] == 2'h0) &&
             (ar != 4'h0) && (ar <= sflash_pkg::AREA_LAST);
  endfunction

  // flat index into the secure store
  function automatic logic [11:0] sec_idx(input logic [23:0] a, input logic [9:0] off);
    logic [3:0] ar;
    ar = a[sflash_pkg::ADR_AREA_MSB:sflash_pkg::ADR_AREA_LSB] - 4'h1;
    sec_idx = {ar[1:0], off};
  endfunction

  // data lines used per clock by the current opcode
  always_comb begin
    unique case (frame_q.op)
      sflash_pkg::OP_DUAL_PROG: lanes = 3'h2;
      sflash_pkg::OP_QUAD_PROG: lanes = 3'h4;
      sflash_pkg::OP_SEC_PROG:  lanes = 3'h1;
      default:                  lanes = 3'h0;
    endcase
  end

  // header counter advance; data opcodes stop at the address end
  always_comb begin
    in_data = (hdr_q == sflash_pkg::HDR_ADDR) && (lanes != 3'h0);
    hdr_d   = hdr_q;
    if (!in_data && hdr_q < sflash_pkg::HDR_READ) begin
      hdr_d = hdr_q + 6'h01;
    end
    dnext = dcnt_q + {1'b0, lanes};
    unique case (lanes)
      3'h4:    dbyte = {dsr_q[3:0], io_i[3:0]};
      3'h2:    dbyte = {dsr_q[5:0], io_i[1:0]};
      default: dbyte = {dsr_q[6:0], io_i[0]};
    endcase
    // page data wraps inside its page, secure data inside its area
    widx = (frame_q.addr[sflash_pkg::ADR_OFF_MSB:0] + frame_q.nb[9:0]) &
           ((lanes == 3'h1) ? sflash_pkg::SEC_MASK : sflash_pkg::PAGE_MASK);
  end

  // per-frame counters, cleared whenever select is high
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      hdr_q  <= 6'h00;
      dcnt_q <= 4'h0;
      dsr_q  <= 8'h00;
      rcnt_q <= 13'h0000;
    end else begin
      hdr_q <= hdr_d;
      if (in_data) begin
        dsr_q  <= dbyte;
        dcnt_q <= (dnext == sflash_pkg::BYTE_BITS) ? 4'h0 : dnext;
      end
      if (hdr_q == sflash_pkg::HDR_READ) begin
        rcnt_q <= rcnt_q + 13'h0001;
      end
    end
  end

  // frame summary; survives select high so the system side can read it
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_q <= '0;
    end else begin
      frame_q.hdr <= hdr_d;
      if (hdr_q == 6'h00) begin
        frame_q.nb  <= 11'h000;
        frame_q.dok <= 1'b0;
      end
      if (hdr_q < sflash_pkg::HDR_OP) begin
        frame_q.op <= {frame_q.op[6:0], io_i[0]};
      end else if (hdr_q < sflash_pkg::HDR_ADDR) begin
        frame_q.addr <= {frame_q.addr[22:0], io_i[0]};
      end
      if (in_data) begin
        frame_q.dok <= (dnext == sflash_pkg::BYTE_BITS);
        if (dnext == sflash_pkg::BYTE_BITS && frame_q.nb != sflash_pkg::SEC_LEN) begin
          frame_q.nb <= frame_q.nb + 11'h001;
        end
      end
    end
  end

  // load buffer; later bytes overwrite earlier ones at the same slot
  always_ff @(posedge sclk_i) begin
    if (!cs_n_i && in_data && dnext == sflash_pkg::BYTE_BITS) begin
      wbuf[widx] <= dbyte;
    end
  end

  // engine busy or asleep, brought over to the link clock
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
    end else begin
      blk_s1_q <= write_in_progress_o | deep_sleep_o;
      blk_s2_q <= blk_s1_q;
    end
  end

  // read data driven on falling edges; secure store is static while not busy
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      io_o    <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (frame_q.op == sflash_pkg::OP_SEC_READ && hdr_q == sflash_pkg::HDR_READ &&
                 sec_ok(frame_q.addr) && !blk_s2_q) begin
      io_oe_o <= 4'h2;
      io_o    <= {2'h0,
                  sec_mem[sec_idx(frame_q.addr, frame_q.addr[sflash_pkg::ADR_OFF_MSB:0] +
                                  rcnt_q[12:3])][~rcnt_q[2:0]], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain (clk_sys_i)
  sflash_pkg::state_t st_q;
  sflash_pkg::kind_t  kind_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        rise;
  logic [31:0] tm_q;
  logic [10:0] idx_q;
  logic [10:0] len_q;
  logic [23:0] base_q;
  logic        wr_ok;
  logic        sec_open;
  logic [2:0]  lock_bit;

  // select synchroniser; frame summary is quiet once select is high
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  // admission checks for the frame just ended
  always_comb begin
    rise     = cs_s2_q && !cs_s3_q;
    wr_ok    = (frame_q.hdr == sflash_pkg::HDR_ADDR) && frame_q.dok &&
               (frame_q.nb != 11'h000) && write_enable_latch_i;
    lock_bit = 3'h1 << (frame_q.addr[13:12] - 2'h1);
    sec_open = sec_ok(frame_q.addr) && ((secure_area_lock_bits_i & lock_bit) == 3'h0);
  end

  // command engine; reset leaves it in standby, never asleep
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= sflash_pkg::ST_IDLE;
      kind_q <= sflash_pkg::K_PAGE;
      tm_q   <= 32'h0;
      len_q  <= 11'h000;
      base_q <= 24'h000000;
    end else begin
      unique case (st_q)
        sflash_pkg::ST_IDLE: if (rise) begin
          base_q <= frame_q.addr;
          unique case (frame_q.op)
            sflash_pkg::OP_DUAL_PROG, sflash_pkg::OP_QUAD_PROG: begin
              // protected pages and quad without quad bit are dropped
              if (wr_ok && block_protect_bits_i == 5'h00 &&
                  (frame_q.op != sflash_pkg::OP_QUAD_PROG || quad_enable_bit_i)) begin
                st_q   <= sflash_pkg::ST_BUSY;
                kind_q <= sflash_pkg::K_PAGE;
                len_q  <= (frame_q.nb > sflash_pkg::PAGE_LEN) ? sflash_pkg::PAGE_LEN : frame_q.nb;
                tm_q   <= PP_CYC;
              end
            end
            sflash_pkg::OP_SEC_PROG: if (wr_ok && sec_open) begin
              st_q   <= sflash_pkg::ST_BUSY;
              kind_q <= sflash_pkg::K_SPROG;
              len_q  <= frame_q.nb;
              tm_q   <= PP_CYC;
            end
            sflash_pkg::OP_SEC_ERASE: if (frame_q.hdr == sflash_pkg::HDR_ADDR &&
                                           write_enable_latch_i && sec_open) begin
              st_q   <= sflash_pkg::ST_BUSY;
              kind_q <= sflash_pkg::K_ERASE;
              len_q  <= sflash_pkg::SEC_LEN;
              tm_q   <= SE_CYC;
            end
            sflash_pkg::OP_SLEEP: if (frame_q.hdr == sflash_pkg::HDR_OP) begin
              st_q <= sflash_pkg::ST_ENTER;
              tm_q <= sflash_pkg::DP_CYC;
            end
            default: ;
          endcase
        end
        sflash_pkg::ST_BUSY: begin
          // ends only once both the timer ran out and every byte is written
          if (tm_q != 32'h0) begin
            tm_q <= tm_q - 32'h1;
          end else if (idx_q == len_q) begin
            st_q <= sflash_pkg::ST_IDLE;
          end
        end
        sflash_pkg::ST_ENTER: begin
          if (tm_q == 32'h0) begin
            st_q <= sflash_pkg::ST_SLEEP;
          end else begin
            tm_q <= tm_q - 32'h1;
          end
        end
        sflash_pkg::ST_SLEEP: begin
          // only the release opcode, exactly eight bits, is heard
          if (rise && frame_q.op == sflash_pkg::OP_RELEASE &&
              frame_q.hdr == sflash_pkg::HDR_OP) begin
            st_q <= sflash_pkg::ST_WAKE;
            tm_q <= sflash_pkg::RES_CYC;
          end
        end
        sflash_pkg::ST_WAKE: begin
          if (tm_q == 32'h0) begin
            st_q <= sflash_pkg::ST_IDLE;
          end else begin
            tm_q <= tm_q - 32'h1;
          end
        end
        default: st_q <= sflash_pkg::ST_IDLE;
      endcase
    end
  end

  // status outputs and end-of-cycle latch clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_in_progress_o <= 1'b0;
      wel_clear_o         <= 1'b0;
      deep_sleep_o        <= 1'b0;
    end else begin
      write_in_progress_o <= (st_q == sflash_pkg::ST_BUSY);
      wel_clear_o <= (st_q == sflash_pkg::ST_BUSY) && (tm_q == 32'h0) &&
                     (idx_q == len_q);
      deep_sleep_o <= (st_q == sflash_pkg::ST_SLEEP) || (st_q == sflash_pkg::ST_WAKE);
    end
  end

  // byte walker: one byte per system clock while busy
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_q      <= 11'h000;
      arr_we_o   <= 1'b0;
      arr_addr_o <= 24'h000000;
      arr_data_o <= 8'h00;
    end else begin
      arr_we_o <= 1'b0;
      if (st_q != sflash_pkg::ST_BUSY) begin
        idx_q <= 11'h000;
      end else if (idx_q != len_q) begin
        idx_q <= idx_q + 11'h001;
        if (kind_q == sflash_pkg::K_PAGE) begin
          arr_we_o   <= 1'b1;
          arr_addr_o <= {base_q[23:8], base_q[sflash_pkg::ADR_PAGE_MSB:0] + idx_q[7:0]};
          arr_data_o <= wbuf[{2'h0, base_q[sflash_pkg::ADR_PAGE_MSB:0] + idx_q[7:0]}];
        end
      end
    end
  end

  // secure store: program only clears bits, erase sets the whole area
  always_ff @(posedge clk_sys_i) begin
    if (st_q == sflash_pkg::ST_BUSY && idx_q != len_q) begin
      if (kind_q == sflash_pkg::K_ERASE) begin
        sec_mem[sec_idx(base_q, idx_q[9:0])] <= sflash_pkg::ERASED;
      end else if (kind_q == sflash_pkg::K_SPROG) begin
        sec_mem[sec_idx(base_q, base_q[9:0] + idx_q[9:0])] <=
          sec_mem[sec_idx(base_q, base_q[9:0] + idx_q[9:0])] & wbuf[base_q[9:0] + idx_q[9:0]];
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/sflash_exec_props.sv
// checker for the serial flash command engine
`timescale 1ns/10ps
`default_nettype none
module sflash_exec_props #(
  parameter int unsigned PP_CYC = 200
) (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  // link
  input wire logic       cs_n_i,
  input wire logic [3:0] io_oe_o,
  // status and array port
  input wire logic       write_in_progress_o,
  input wire logic       wel_clear_o,
  input wire logic       deep_sleep_o,
  input wire logic       arr_we_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  int unsigned busy_q;
  // length of the busy span; counted here since a repeat cannot reach it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_q <= 0;
    else busy_q <= write_in_progress_o ? busy_q + 1 : 0;
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_cyc_end;
    $fell(write_in_progress_o);
  endsequence
  sequence s_sleep_start;
    $rose(deep_sleep_o);
  endsequence
  // the clear pulse stands in the last busy cycle, so the latch drops with the progress flag
  property p_end_clear; s_cyc_end |-> $past(wel_clear_o); endproperty
  a_end_clear: assert property (p_end_clear) else $error("no latch clear at cycle end");
  property p_clear_pulse;
    wel_clear_o |-> write_in_progress_o ##1 (!write_in_progress_o && !wel_clear_o);
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("latch clear not a pulse");
  property p_min_len; s_cyc_end |-> busy_q >= PP_CYC; endproperty
  a_min_len: assert property (p_min_len) else $error("busy span too short");
  property p_write_busy; arr_we_o |-> write_in_progress_o; endproperty
  a_write_busy: assert property (p_write_busy) else $error("array write outside cycle");
  property p_oe_code; io_oe_o == 4'h0 || io_oe_o == 4'h2; endproperty
  a_oe_code: assert property (p_oe_code) else $error("bad output enable");
  property p_oe_idle; cs_n_i [*2] |-> io_oe_o == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driving while deselected");
  property p_wip_after_cs; $rose(write_in_progress_o) |-> cs_n_i && $past(cs_n_i, 2); endproperty
  a_wip_after_cs: assert property (p_wip_after_cs) else $error("cycle began in a frame");
  property p_sleep_quiet; deep_sleep_o |-> !write_in_progress_o && !arr_we_o; endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep");
  property p_sleep_hold; s_sleep_start |=> deep_sleep_o [*8]; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left too early");
  property p_sleep_entry; s_sleep_start |-> $past(cs_n_i, 8); endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without entry delay");
  property p_power_up; $rose(rst_n_i) |-> !deep_sleep_o; endproperty
  a_power_up: assert property (p_power_up) else $error("asleep after reset");
endmodule
bind sflash_exec sflash_exec_props #(.PP_CYC(PP_CYC)) u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i), .io_oe_o(io_oe_o), .write_in_progress_o(write_in_progress_o), .wel_clear_o(wel_clear_o),
  .deep_sleep_o(deep_sleep_o), .arr_we_o(arr_we_o));
`default_nettype wire

// ===== verif/sflash_host.sv
// host-side model that issues frames on the serial link
`timescale 1ns/10ps
`default_nettype none
module sflash_host (
  // link pins
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] io_o,
  // returned data line
  input  wire logic  io1_i
);
  logic [7:0] dq [4];
  logic [7:0] rq [4];
  // link clock stands still and select is high between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    io_o   = 4'hA;
    // a real select edge after time zero, so the link counters surely clear
    #1 cs_n_o = 1'b1;
  end
  // one link clock; the return line is taken at the rise
  task automatic tick(output logic s);
    #6 sclk_o = 1'b1;
    s = io1_i;
    #6 sclk_o = 1'b0;
  endtask
  // header on line 0, nb bytes w bits a clock, then xb stray clocks
  task automatic send(input logic [39:0] h, input int hb, input int w, input int nb, input int xb);
    logic s;
    cs_n_o = 1'b0;
    for (int i = 0; i < hb; i++) begin
      io_o[0] = h[39-i];
      tick(s);
    end
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8; j += w) begin
        for (int m = 0; m < w; m++)
          io_o[m] = dq[k][7-j-w+1+m];
        tick(s);
        rq[k][7-j] = s;
      end
    end
    // stray clocks break the byte boundary on purpose
    for (int x = 0; x < xb; x++)
      tick(s);
    #6 cs_n_o = 1'b1;
    io_o = ~io_o; // released lines keep no stale value
  endtask
endmodule
`default_nettype wire

// ===== verif/sflash_exec_tb.sv
// self-checking bench for the serial flash command engine
`timescale 1ns/10ps
`default_nettype none
module sflash_exec_tb;
  logic        clk_sys;
  logic        rst_n;
  logic [9:0]  st;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  h_io;
  logic [3:0]  dev_io;
  logic [3:0]  oe;
  logic [3:0]  io_w;
  logic        write_in_progress;
  logic        dsl;
  logic        we;
  logic [23:0] waddr;
  logic [7:0]  wdata;
  logic        wclr;
  int          n_clr;
  logic [31:0] wq [$];
  int          fail_count;
  int          num_checks;
  // wire level from the device enables; the host drives every line the device leaves off
  assign io_w = (oe & dev_io) | (~oe & h_io);
  sflash_exec #(.PP_CYC(200), .SE_CYC(1200)) u_sflash_exec (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w), .io_o(dev_io), .io_oe_o(oe), .write_enable_latch_i(st[9]),
    .quad_enable_bit_i(st[8]), .secure_area_lock_bits_i(st[7:5]), .block_protect_bits_i(st[4:0]),
    .write_in_progress_o(write_in_progress), .wel_clear_o(wclr), .deep_sleep_o(dsl), .arr_we_o(we), .arr_addr_o(waddr),
    .arr_data_o(wdata));
  sflash_host u_sflash_host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io), .io1_i(io_w[1]));
  // record every main-array write
  always @(posedge clk_sys) if (we === 1'b1) wq.push_back({waddr, wdata});
  // count end-of-cycle latch clear pulses
  always @(posedge clk_sys) if (wclr === 1'b1) n_clr++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // status bits change just after an edge
  task automatic set_st(input logic [9:0] v);
    @(posedge clk_sys);
    #1 st = v;
  endtask
  // one frame, then whether a busy cycle followed; waits it out
  task automatic frame(input logic [39:0] h, input int hb, input int w, input int nb, input int xb,
                       output logic ran);
    wq.delete();
    n_clr = 0;
    u_sflash_host.send(h, hb, w, nb, xb);
    repeat (20) @(posedge clk_sys);
    #1 ran = (write_in_progress === 1'b1);
    for (int i = 0; i < 3000 && write_in_progress !== 1'b0; i++) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_quad();
    logic r;
    set_st(10'h300);
    u_sflash_host.dq[0] = 8'h5A;
    u_sflash_host.dq[1] = 8'hC3;
    frame({sflash_pkg::OP_QUAD_PROG, 24'h0012FF, 8'h00}, 32, 4, 2, 0, r);
    chk("quad ran", 1, r);
    chk("quad count", 2, wq.size());
    chk("quad b0", {24'h0012FF, 8'h5A}, wq[0]);
    chk("quad b1", {24'h001200, 8'hC3}, wq[1]);
    chk("quad clear", 1, n_clr);
    u_sflash_host.dq[0] = 8'h96;
    frame({sflash_pkg::OP_DUAL_PROG, 24'h000340, 8'h00}, 32, 2, 1, 0, r);
    chk("dual ran", 1, r);
    chk("dual b0", {24'h000340, 8'h96}, wq[0]);
  endtask
  task automatic t_refuse();
    logic r;
    set_st(10'h200);
    frame({sflash_pkg::OP_QUAD_PROG, 24'h0, 8'h00}, 32, 4, 1, 0, r);
    chk("no quad bit", 0, r);
    set_st(10'h300);
    frame({sflash_pkg::OP_DUAL_PROG, 24'h0, 8'h00}, 32, 2, 1, 3, r);
    chk("partial byte", 0, r);
    set_st(10'h301);
    frame({sflash_pkg::OP_DUAL_PROG, 24'h0, 8'h00}, 32, 2, 1, 0, r);
    chk("protected", 0, r);
    set_st(10'h100);
    frame({sflash_pkg::OP_DUAL_PROG, 24'h0, 8'h00}, 32, 2, 1, 0, r);
    chk("no latch", 0, r);
    chk("no clear", 0, n_clr);
  endtask
  task automatic t_sec();
    logic r;
    set_st(10'h300);
    frame({sflash_pkg::OP_SEC_ERASE, 24'h002000, 8'h00}, 32, 1, 0, 1, r);
    chk("erase odd", 0, r);
    frame({sflash_pkg::OP_SEC_ERASE, 24'h002000, 8'h00}, 32, 1, 0, 0, r);
    chk("erase ran", 1, r);
    chk("erase clear", 1, n_clr);
    frame({sflash_pkg::OP_SEC_ERASE, 24'h004000, 8'h00}, 32, 1, 0, 0, r);
    chk("bad area", 0, r);
    u_sflash_host.dq[0] = 8'hA5;
    u_sflash_host.dq[1] = 8'h3C;
    frame({sflash_pkg::OP_SEC_PROG, 24'h0023FF, 8'h00}, 32, 1, 2, 0, r);
    chk("sprog ran", 1, r);
    chk("array idle", 0, wq.size());
    frame({sflash_pkg::OP_SEC_READ, 24'h0023FF, 8'h00}, 40, 1, 3, 0, r);
    chk("rd 3FF", 8'hA5, u_sflash_host.rq[0]);
    chk("rd 000", 8'h3C, u_sflash_host.rq[1]);
    chk("rd 001", 8'hFF, u_sflash_host.rq[2]);
    set_st(10'h340);
    frame({sflash_pkg::OP_SEC_ERASE, 24'h002000, 8'h00}, 32, 1, 0, 0, r);
    chk("locked", 0, r);
    frame({sflash_pkg::OP_SEC_ERASE, 24'h001000, 8'h00}, 32, 1, 0, 0, r);
    chk("area one", 1, r);
    frame({sflash_pkg::OP_SEC_READ, 24'h0023FF, 8'h00}, 40, 1, 1, 0, r);
    chk("kept", 8'hA5, u_sflash_host.rq[0]);
  endtask
  task automatic t_sleep();
    logic r;
    set_st(10'h300);
    frame({sflash_pkg::OP_SLEEP, 32'h0}, 9, 1, 0, 0, r);
    repeat (80) @(posedge clk_sys);
    #1 chk("odd sleep", 0, dsl);
    frame({sflash_pkg::OP_SLEEP, 32'h0}, 8, 1, 0, 0, r);
    chk("entry wait", 0, dsl);
    repeat (60) @(posedge clk_sys);
    #1 chk("asleep", 1, dsl);
    frame({sflash_pkg::OP_QUAD_PROG, 24'h0, 8'h00}, 32, 4, 1, 0, r);
    chk("ignored", 0, r);
    frame({sflash_pkg::OP_RELEASE, 32'h0}, 8, 1, 0, 0, r);
    chk("waking", 1, dsl);
    repeat (200) @(posedge clk_sys);
    #1 chk("awake", 0, dsl);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // main sequence
  initial begin
    rst_n = 1'b1;
    st = 10'h000;
    fail_count = 0;
    num_checks = 0;
    // assert after time zero so the reset edge cannot be missed
    #1 rst_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("reset sleep", 0, dsl);
    chk("reset busy", 0, write_in_progress);
    t_quad();
    t_refuse();
    t_sec();
    t_sleep();
    end_sim();
  end
  // the tests take well under half a millisecond
  initial begin
    #2_000_000;
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
